// ===== verilog/supply_wd_supervisor.sv
// supply fault latching, switching delay report and timeout watchdog
//
// Functional notes
// - battery low-off latches gates off; logic keeps state
// - battery low sets supply, battery and pump flags
// - battery low clears on status clear above low-on
// - battery above chosen high level: gates off, pump stops
// - high sets flags; pump restarts below on; clear frees gates
// - forced discharge uses static discharge setting
// - logic reset holds all logic reset, gates off
// - pump low: discharge for cross conduction time, then off
// - pump low sets pump, supply and global error flags
// - pump flags clear with pump good, after recovery delay
// - pump low reported after charge timeout from reset
// - delays and edge times of active or pwm gate
// - mask time first in motor mode reports mask as on delay
// - cross conduction first reports it, or generator mode
// - period chosen by period select bit
// - runs from reset; toggle starts 0; inversion restarts
// - failure on timeout or same toggle value
// - failure latches failsafe, controls default, gates off
// - exit: clear, toggle 1, toggle 0, in period, nothing else
// - progress field gives quarter of the period
// - short period timeout keeps progress field
// - disable: unlock then off frame; off 0 re-enables
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module supply_wd_supervisor #(
  parameter int RECOVERY_CYCLES = `RECOVERY_CYCLES,
  parameter int PUMP_CHARGE_CYCLES = `PUMP_CHARGE_CYCLES,
  parameter int WD_TICK_CYCLES = `WD_TICK_CYCLES,
  parameter int WD_SHORT_TICKS = `WD_SHORT_TICKS,
  parameter int WD_LONG_TICKS = `WD_LONG_TICKS
) (
  // clock and logic supply reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // supply comparators, asynchronous
  input wire logic battery_below_low_off_i,
  input wire logic battery_above_low_on_i,
  input wire logic battery_above_high1_i,
  input wire logic battery_above_high2_i,
  input wire logic battery_below_high_on_i,
  input wire logic pump_below_level_i,
  input wire logic thermal_shutdown_i,
  // decoded frames from the serial interface
  input wire logic frame_end_i,
  input wire logic frame_clear_status_i,
  input wire logic frame_write_one_i,
  input wire logic frame_write_two_i,
  input wire logic wd_toggle_bit_i,
  input wire logic wd_period_select_i,
  input wire logic battery_high_level_select_i,
  input wire logic unlock_i,
  input wire logic wd_off_bit_i,
  // switching measurement
  input wire logic generator_detect_enable_i,
  input wire logic active_cmd_i,
  input wire logic pwm_cmd_i,
  input wire logic out_low_cross_i,
  input wire logic out_high_cross_i,
  input wire supervisor_pkg::meas_type ds_mask_time_i,
  input wire supervisor_pkg::meas_type cross_conduction_time_i,
  // fault flags
  output logic supply_error_flag_o,
  output logic battery_low_flag_o,
  output logic battery_high_flag_o,
  output logic pump_low_flag_o,
  output logic global_error_flag_o,
  // gate and pump control
  output logic bridge_enable_o,
  output logic static_discharge_o,
  output logic driver_off_o,
  output logic pump_enable_o,
  // control readback
  output logic wd_toggle_bit_o,
  output logic wd_period_select_o,
  output logic battery_high_level_select_o,
  output logic wd_off_bit_o,
  // watchdog status
  output logic failsafe_flag_o,
  output logic [1:0] wd_progress_field_o,
  // measured times
  output supervisor_pkg::meas_type ton_delay_o,
  output supervisor_pkg::meas_type toff_delay_o,
  output supervisor_pkg::meas_type rise_time_o,
  output supervisor_pkg::meas_type fall_time_o,
  output logic generator_mode_o
);
  import supervisor_pkg::*;

  localparam int NS = 9;
  localparam int RW = $clog2(RECOVERY_CYCLES + 1);
  localparam int SW = $clog2(PUMP_CHARGE_CYCLES + 1);

  logic [NS-1:0] raw;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic s_uv_off, s_uv_on, s_ov1, s_ov2, s_ov_on, s_pump, s_tsd, s_lo, s_hi;
  logic uv_set, ov_set, pump_set, clear;
  logic next_battery_low, next_battery_high, next_pump_low;
  logic [RW-1:0] rec_cnt;
  logic [SW-1:0] start_cnt;
  logic start_done;
  logic pump_stop;
  meas_type dis_cnt;
  logic supply_off;
  logic unlock;
  logic wd_timeout;
  logic trig_wr, trig_ok, trig_bad, wd_fail, wd_restart;
  fs_state_type fs_state;
  logic seq_step;
  meas_state_type m_state;
  meas_type m_cnt;
  logic cmd, cmd_d, lo_d, hi_d;

  // two-stage synchronisers for comparator inputs
  assign raw = {battery_below_low_off_i, battery_above_low_on_i, battery_above_high1_i,
                battery_above_high2_i, battery_below_high_on_i, pump_below_level_i,
                thermal_shutdown_i, out_low_cross_i, out_high_cross_i};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
      end else begin
        sync1[i] <= raw[i];
        sync2[i] <= sync1[i];
      end
    end
  end
  assign {s_uv_off, s_uv_on, s_ov1, s_ov2, s_ov_on, s_pump, s_tsd, s_lo, s_hi} = sync2;

  // fault conditions
  assign clear = frame_end_i && frame_clear_status_i;
  assign uv_set = s_uv_off;
  assign ov_set = battery_high_level_select_o ? s_ov2 : s_ov1;
  assign pump_set = (s_pump && start_done) || uv_set || ov_set || s_tsd;

  // next flag values, set wins over clear
  always_comb begin
    next_battery_low = battery_low_flag_o;
    next_battery_high = battery_high_flag_o;
    next_pump_low = pump_low_flag_o;
    if (uv_set) begin
      next_battery_low = 1'b1;
    end else if (clear && s_uv_on) begin
      next_battery_low = 1'b0;
    end
    if (ov_set) begin
      next_battery_high = 1'b1;
    end else if (clear && s_ov_on) begin
      next_battery_high = 1'b0;
    end
    if (pump_set) begin
      next_pump_low = 1'b1;
    end else if (clear && !s_pump && rec_cnt == '0) begin
      next_pump_low = 1'b0;
    end
  end

  // latched fault flags
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      battery_low_flag_o <= 1'b0;
      battery_high_flag_o <= 1'b0;
      pump_low_flag_o <= 1'b0;
      supply_error_flag_o <= 1'b0;
      global_error_flag_o <= 1'b0;
    end else begin
      battery_low_flag_o <= next_battery_low;
      battery_high_flag_o <= next_battery_high;
      pump_low_flag_o <= next_pump_low;
      if (pump_set) begin
        supply_error_flag_o <= 1'b1;
        global_error_flag_o <= 1'b1;
      end else if (clear) begin
        supply_error_flag_o <= next_battery_low || next_battery_high || next_pump_low;
        global_error_flag_o <= next_pump_low;
      end
    end
  end

  // pump flag hold-off after supply or thermal fault
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rec_cnt <= '0;
    end else if (uv_set || ov_set || s_tsd) begin
      rec_cnt <= RW'(RECOVERY_CYCLES);
    end else if (rec_cnt != '0) begin
      rec_cnt <= rec_cnt - 1'b1;
    end
  end

  // pump charge window after reset
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      start_cnt <= '0;
    end else if (!start_done) begin
      start_cnt <= start_cnt + 1'b1;
    end
  end
  assign start_done = (start_cnt == SW'(PUMP_CHARGE_CYCLES));

  // pump stop on high battery, restart below on level
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pump_stop <= 1'b0;
    end else if (ov_set) begin
      pump_stop <= 1'b1;
    end else if (s_ov_on) begin
      pump_stop <= 1'b0;
    end
  end

  // discharge window when the pump collapses
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      dis_cnt <= '0;
    end else if (next_pump_low && !pump_low_flag_o) begin
      dis_cnt <= cross_conduction_time_i;
    end else if (dis_cnt != '0) begin
      dis_cnt <= dis_cnt - 1'b1;
    end
  end

  // gate and pump drive
  assign supply_off = battery_low_flag_o || battery_high_flag_o || s_tsd || failsafe_flag_o;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bridge_enable_o <= 1'b0;
      static_discharge_o <= 1'b0;
      driver_off_o <= 1'b1;
      pump_enable_o <= 1'b0;
    end else begin
      bridge_enable_o <= !(supply_off || pump_low_flag_o);
      static_discharge_o <= supply_off || (pump_low_flag_o && dis_cnt != '0);
      driver_off_o <= pump_low_flag_o && dis_cnt == '0 && !supply_off;
      pump_enable_o <= !(pump_stop || s_uv_off || s_tsd);
    end
  end

  // watchdog trigger checks
  assign trig_wr = frame_end_i && frame_write_one_i && !failsafe_flag_o && !wd_off_bit_o;
  assign trig_ok = trig_wr && (wd_toggle_bit_i != wd_toggle_bit_o);
  assign trig_bad = trig_wr && (wd_toggle_bit_i == wd_toggle_bit_o);
  assign wd_fail = (wd_timeout && !failsafe_flag_o) || trig_bad;
  // a timeout restarts the timer itself; restarting here would wipe the frozen field
  assign wd_restart = trig_ok || trig_bad || seq_step;

  // control bits, held at defaults in failsafe
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || wd_fail || failsafe_flag_o) begin
      wd_toggle_bit_o <= `TOGGLE_RST;
      wd_period_select_o <= `PERIOD_SEL_RST;
      battery_high_level_select_o <= `HIGH_SEL_RST;
    end else if (frame_end_i && frame_write_one_i) begin
      wd_toggle_bit_o <= wd_toggle_bit_i;
      wd_period_select_o <= wd_period_select_i;
      battery_high_level_select_o <= battery_high_level_select_i;
    end
  end

  // guarded watchdog disable
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || wd_fail || failsafe_flag_o) begin
      unlock <= `UNLOCK_RST;
      wd_off_bit_o <= `WD_OFF_RST;
    end else if (frame_end_i) begin
      unlock <= frame_write_one_i && unlock_i;
      if (frame_write_two_i && !wd_off_bit_i) begin
        wd_off_bit_o <= 1'b0;
      end else if (frame_write_two_i && unlock) begin
        wd_off_bit_o <= 1'b1;
      end
    end
  end

  // failsafe exit sequence
  always_comb begin
    seq_step = 1'b0;
    if (frame_end_i && fs_state != FS_NONE) begin
      seq_step = frame_clear_status_i
                 || (fs_state == FS_WAIT_ONE && frame_write_one_i && wd_toggle_bit_i)
                 || (fs_state == FS_WAIT_ZERO && frame_write_one_i && !wd_toggle_bit_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      fs_state <= FS_NONE;
      failsafe_flag_o <= 1'b0;
    end else begin
      case (fs_state)
        FS_NONE: begin
          if (wd_fail) begin
            fs_state <= FS_WAIT_CLEAR;
            failsafe_flag_o <= 1'b1;
          end
        end
        default: begin
          if (wd_timeout) begin
            fs_state <= FS_WAIT_CLEAR;
          end else if (frame_end_i && frame_clear_status_i) begin
            fs_state <= FS_WAIT_ONE;
          end else if (frame_end_i && !seq_step) begin
            fs_state <= FS_WAIT_CLEAR;
          end else if (seq_step && fs_state == FS_WAIT_ONE) begin
            fs_state <= FS_WAIT_ZERO;
          end else if (seq_step && fs_state == FS_WAIT_ZERO) begin
            fs_state <= FS_NONE;
            failsafe_flag_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // watchdog period counter
  wd_timer #(
    .TICK_CYCLES(WD_TICK_CYCLES),
    .SHORT_TICKS(WD_SHORT_TICKS),
    .LONG_TICKS(WD_LONG_TICKS)
  ) u_wd_timer (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .run_i(!wd_off_bit_o),
    .restart_i(wd_restart),
    .long_i(wd_period_select_o),
    .timeout_o(wd_timeout),
    .progress_o(wd_progress_field_o)
  );

  // switching measurement on the selected gate
  assign cmd = generator_detect_enable_i ? active_cmd_i : pwm_cmd_i;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cmd_d <= 1'b0;
      lo_d <= 1'b0;
      hi_d <= 1'b0;
    end else begin
      cmd_d <= cmd;
      lo_d <= s_lo;
      hi_d <= s_hi;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      m_state <= M_IDLE;
      m_cnt <= '0;
      ton_delay_o <= '0;
      toff_delay_o <= '0;
      rise_time_o <= '0;
      fall_time_o <= '0;
      generator_mode_o <= 1'b0;
    end else if (cmd && !cmd_d) begin
      m_state <= M_ON;
      m_cnt <= '0;
    end else if (!cmd && cmd_d) begin
      m_state <= M_OFF;
      m_cnt <= '0;
    end else begin
      if (m_cnt != '1) begin
        m_cnt <= m_cnt + 1'b1;
      end
      case (m_state)
        M_ON: begin
          if (s_lo && !lo_d) begin
            ton_delay_o <= m_cnt;
            m_state <= M_RISE;
            m_cnt <= '0;
          end else if (m_cnt >= ds_mask_time_i && !generator_mode_o) begin
            ton_delay_o <= ds_mask_time_i;
            m_state <= M_IDLE;
          end
        end
        M_RISE: begin
          if (s_hi && !hi_d) begin
            rise_time_o <= m_cnt;
            m_state <= M_IDLE;
          end
        end
        M_OFF: begin
          if (!s_hi && hi_d) begin
            toff_delay_o <= m_cnt;
            generator_mode_o <= 1'b0;
            m_state <= M_FALL;
            m_cnt <= '0;
          end else if (m_cnt >= cross_conduction_time_i) begin
            if (generator_detect_enable_i) begin
              generator_mode_o <= 1'b1;
            end else begin
              toff_delay_o <= cross_conduction_time_i;
            end
            m_state <= M_IDLE;
          end
        end
        M_FALL: begin
          if (!s_lo && lo_d) begin
            fall_time_o <= m_cnt;
            m_state <= M_IDLE;
          end
        end
        default: begin
          m_state <= M_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== verilog/supervisor_consts.svh
// reset values and timing counts of the supply and watchdog supervisor
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

`define CLK_PERIOD_NS 5
// watchdog prescaler tick and periods
`define WD_TICK_NS 1000
`define WD_TICK_CYCLES ((`WD_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WD_SHORT_MS 50
`define WD_LONG_MS 200
`define WD_SHORT_TICKS (`WD_SHORT_MS * 1000000 / `WD_TICK_NS)
`define WD_LONG_TICKS (`WD_LONG_MS * 1000000 / `WD_TICK_NS)
// pump flag hold-off after a supply or thermal fault
`define RECOVERY_NS 64000
`define RECOVERY_CYCLES ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// pump charge timeout after reset, no figure known
`define PUMP_CHARGE_CYCLES 4000
// control reset values
`define TOGGLE_RST 1'h0
`define PERIOD_SEL_RST 1'h0
`define HIGH_SEL_RST 1'h0
`define UNLOCK_RST 1'h0
`define WD_OFF_RST 1'h0
// measurement counter width
`define MEAS_W 12
// progress field codes
`define PROG_Q0 2'h0
`define PROG_Q1 2'h1
`define PROG_Q2 2'h2
`define PROG_Q3 2'h3

`endif

// ===== verilog/supervisor_pkg.sv
// types shared by the supply and watchdog supervisor
`include "supervisor_consts.svh"
package supervisor_pkg;
  typedef enum logic [1:0] {
    FS_NONE = 2'h0,
    FS_WAIT_CLEAR = 2'h1,
    FS_WAIT_ONE = 2'h2,
    FS_WAIT_ZERO = 2'h3
  } fs_state_type;
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_ON = 3'h1,
    M_RISE = 3'h2,
    M_OFF = 3'h3,
    M_FALL = 3'h4
  } meas_state_type;
  typedef logic [`MEAS_W-1:0] meas_type;
endpackage

// ===== verilog/wd_timer.sv
// watchdog prescaler, period counter and progress field
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module wd_timer #(
  parameter int TICK_CYCLES = `WD_TICK_CYCLES,
  parameter int SHORT_TICKS = `WD_SHORT_TICKS,
  parameter int LONG_TICKS = `WD_LONG_TICKS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // control
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic long_i,
  // status
  output logic timeout_o,
  output logic [1:0] progress_o
);
  localparam int CW = $clog2(LONG_TICKS + 1);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  logic [PW-1:0] pre;
  logic tick;
  logic [CW-1:0] count;
  logic [CW-1:0] period;
  logic [CW+1:0] c4;
  logic [CW+1:0] p1;
  logic [1:0] quarter;
  logic hold;
  logic expire;

  // prescaler gives one tick per fixed number of clocks
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !run_i || restart_i) begin
      pre <= '0;
      tick <= 1'b0;
    end else if (pre == PW'(TICK_CYCLES - 1)) begin
      pre <= '0;
      tick <= 1'b1;
    end else begin
      pre <= pre + 1'b1;
      tick <= 1'b0;
    end
  end

  // period choice and end of period
  assign period = long_i ? CW'(LONG_TICKS) : CW'(SHORT_TICKS);
  assign expire = run_i && !restart_i && tick && (count == period - 1'b1);

  // tick counter, restarted by a trigger
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !run_i || restart_i || expire) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= expire;
    end
  end

  // quarter of the period reached
  assign c4 = {count, 2'h0};
  assign p1 = {2'h0, period};
  always_comb begin
    if (c4 >= p1 + (p1 << 1)) begin
      quarter = `PROG_Q3;
    end else if (c4 >= (p1 << 1)) begin
      quarter = `PROG_Q2;
    end else if (c4 >= p1) begin
      quarter = `PROG_Q1;
    end else begin
      quarter = `PROG_Q0;
    end
  end

  // short period timeout leaves the field standing
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || restart_i || long_i) begin
      hold <= 1'b0;
    end else if (expire) begin
      hold <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      progress_o <= `PROG_Q0;
    end else if (!(hold || (expire && !long_i))) begin
      progress_o <= quarter;
    end
  end
endmodule

// ===== verification/supply_wd_supervisor_assertions.sv
// port checks for the supply and watchdog supervisor
`timescale 1ns/100ps
module supply_wd_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // frames
  input wire logic frame_end_i,
  input wire logic frame_write_one_i,
  input wire logic wd_toggle_bit_i,
  // flags and gates
  input wire logic supply_error_flag_o,
  input wire logic battery_low_flag_o,
  input wire logic battery_high_flag_o,
  input wire logic pump_low_flag_o,
  input wire logic global_error_flag_o,
  input wire logic bridge_enable_o,
  input wire logic driver_off_o,
  input wire logic pump_enable_o,
  // watchdog
  input wire logic wd_toggle_bit_o,
  input wire logic wd_period_select_o,
  input wire logic wd_off_bit_o,
  input wire logic failsafe_flag_o,
  input wire logic [1:0] wd_progress_field_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // fault flags and gate reaction
  property p_uv_flags; $rose(battery_low_flag_o) |-> supply_error_flag_o && pump_low_flag_o;
  endproperty
  a_uv_flags: assert property (p_uv_flags) else $error("low flag alone");
  property p_uv_off; battery_low_flag_o |=> !bridge_enable_o; endproperty
  a_uv_off: assert property (p_uv_off) else $error("gates on in low");
  property p_ov_off; $rose(battery_high_flag_o) |=> !pump_enable_o && !bridge_enable_o;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("high not off");
  property p_pump; pump_low_flag_o |-> global_error_flag_o && supply_error_flag_o; endproperty
  a_pump: assert property (p_pump) else $error("pump flag alone");
  // watchdog behaviour
  property p_same;
    frame_end_i && frame_write_one_i && !failsafe_flag_o && !wd_off_bit_o
      && wd_toggle_bit_i == wd_toggle_bit_o |=> failsafe_flag_o;
  endproperty
  a_same: assert property (p_same) else $error("rewrite missed");
  property p_fs_hold;
    failsafe_flag_o && $past(failsafe_flag_o) |->
      !wd_toggle_bit_o && !wd_period_select_o && !bridge_enable_o;
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("failsafe not held");
  property p_prog;
    $changed(wd_progress_field_o) |-> wd_progress_field_o == 2'h0
      || wd_progress_field_o == 2'($past(wd_progress_field_o) + 2'h1);
  endproperty
  a_prog: assert property (p_prog) else $error("progress skipped");
  property p_rst; $rose(reset_n_i) |-> driver_off_o && !bridge_enable_o && !failsafe_flag_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // main scenarios
  c_fs: cover property ($rose(failsafe_flag_o));
  c_uv: cover property ($rose(battery_low_flag_o));
  c_drv: cover property ($rose(driver_off_o));
endmodule
bind supply_wd_supervisor supply_wd_checker chk_i (.*);

// ===== verification/host_model.sv
// host model issuing decoded serial frames
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clock_i,
  // decoded frame
  output logic frame_end_o,
  output logic clear_o,
  output logic write_one_o,
  output logic write_two_o,
  output logic [4:0] data_o
);
  // idle, no frame
  initial begin
    {frame_end_o, clear_o, write_one_o, write_two_o, data_o} = 9'h000;
  end
  // kind: 0 read, 1 clear, 2 ctrl one, 3 ctrl two
  task automatic send(input logic [1:0] kind, input logic [4:0] data);
    @(negedge clock_i);
    frame_end_o = 1'b1;
    clear_o = (kind == 2'h1);
    write_one_o = (kind == 2'h2);
    write_two_o = (kind == 2'h3);
    data_o = data;
    @(negedge clock_i);
    {frame_end_o, clear_o, write_one_o, write_two_o} = 4'h0;
    data_o = ~data;
  endtask
endmodule

// ===== verification/supply_wd_supervisor_tb_top.sv
// self-checking bench for the supply and watchdog supervisor
`timescale 1ns/100ps
module supply_wd_supervisor_tb_top;
  import supervisor_pkg::*;
  // design signals
  logic clock_i, reset_n_i, battery_below_low_off_i, battery_above_low_on_i;
  logic battery_above_high1_i, battery_above_high2_i, battery_below_high_on_i;
  logic pump_below_level_i, thermal_shutdown_i, frame_end_i, frame_clear_status_i;
  logic frame_write_one_i, frame_write_two_i, wd_toggle_bit_i, wd_period_select_i;
  logic battery_high_level_select_i, unlock_i, wd_off_bit_i, generator_detect_enable_i;
  logic active_cmd_i, pwm_cmd_i, out_low_cross_i, out_high_cross_i;
  meas_type ds_mask_time_i, cross_conduction_time_i, ton_delay_o, toff_delay_o;
  meas_type rise_time_o, fall_time_o;
  logic supply_error_flag_o, battery_low_flag_o, battery_high_flag_o, pump_low_flag_o;
  logic global_error_flag_o, bridge_enable_o, static_discharge_o, driver_off_o;
  logic pump_enable_o, wd_toggle_bit_o, wd_period_select_o, battery_high_level_select_o;
  logic wd_off_bit_o, failsafe_flag_o, generator_mode_o, tog;
  logic [1:0] wd_progress_field_o;
  int mismatches = 0;
  int total_checks = 0;
  // design, short counts, and host
  supply_wd_supervisor #(.RECOVERY_CYCLES(20), .PUMP_CHARGE_CYCLES(20), .WD_TICK_CYCLES(2),
    .WD_SHORT_TICKS(16), .WD_LONG_TICKS(64)) dut (.*);
  host_model host (.clock_i, .frame_end_o(frame_end_i), .clear_o(frame_clear_status_i),
    .write_one_o(frame_write_one_i), .write_two_o(frame_write_two_i),
    .data_o({wd_toggle_bit_i, wd_period_select_i, battery_high_level_select_i, unlock_i,
    wd_off_bit_i}));
  // clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic w1(input logic per, input logic hs, input logic unl);
    tog = ~tog;
    host.send(2'h2, {tog, per, hs, unl, 1'b0});
  endtask
  task automatic clr;
    host.send(2'h1, 5'h00);
    cyc(2);
  endtask
  task automatic wait_fs(input int n);
    for (int i = 0; i < n && failsafe_flag_o !== 1'b1; i++) cyc(1);
    if (failsafe_flag_o !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  task automatic exit_fs;
    host.send(2'h1, 5'h00);
    host.send(2'h2, 5'h10);
    host.send(2'h2, 5'h00);
    tog = 1'b0;
    cyc(2);
    chk(failsafe_flag_o, 1'b0);
    chk(bridge_enable_o, 1'b1);
  endtask
  // charge window, first trigger, disable
  task automatic t_start;
    cyc(10);
    chk(pump_low_flag_o, 1'b0);
    chk(wd_toggle_bit_o, 1'b0);
    cyc(14);
    chk(pump_low_flag_o, 1'b1);
    pump_below_level_i = 1'b0;
    w1(1'b0, 1'b0, 1'b0);
    chk(wd_toggle_bit_o, 1'b1);
    clr;
    chk(pump_low_flag_o, 1'b0);
    w1(1'b0, 1'b0, 1'b1);
    host.send(2'h3, 5'h01);
    chk(wd_off_bit_o, 1'b1);
    cyc(150);
    chk(failsafe_flag_o, 1'b0);
  endtask
  // battery low, clear refused while low
  task automatic t_uv;
    {battery_below_low_off_i, battery_above_low_on_i} = 2'h2;
    cyc(5);
    chk(battery_low_flag_o & pump_low_flag_o & supply_error_flag_o, 1'b1);
    chk(bridge_enable_o, 1'b0);
    chk(static_discharge_o, 1'b1);
    battery_below_low_off_i = 1'b0;
    clr;
    chk(battery_low_flag_o, 1'b1);
    battery_above_low_on_i = 1'b1;
    cyc(4);
    clr;
    chk(battery_low_flag_o, 1'b0);
    chk(pump_low_flag_o, 1'b1);
    cyc(24);
    clr;
    chk(pump_low_flag_o | supply_error_flag_o, 1'b0);
    chk(bridge_enable_o, 1'b1);
  endtask
  // battery high with the upper level selected
  task automatic t_ov;
    w1(1'b0, 1'b1, 1'b0);
    chk(battery_high_level_select_o, 1'b1);
    {battery_above_high1_i, battery_below_high_on_i} = 2'h2;
    cyc(5);
    chk(battery_high_flag_o, 1'b0);
    battery_above_high2_i = 1'b1;
    cyc(5);
    chk(battery_high_flag_o & supply_error_flag_o & pump_low_flag_o, 1'b1);
    chk(pump_enable_o | bridge_enable_o, 1'b0);
    chk(static_discharge_o, 1'b1);
    {battery_above_high1_i, battery_above_high2_i, battery_below_high_on_i} = 3'h1;
    cyc(5);
    chk(pump_enable_o, 1'b1);
    chk(bridge_enable_o, 1'b0);
    cyc(24);
    clr;
    chk(battery_high_flag_o | pump_low_flag_o, 1'b0);
    chk(bridge_enable_o, 1'b1);
    w1(1'b0, 1'b0, 1'b0);
  endtask
  // pump low: discharge window, then drivers off
  task automatic t_pump;
    cross_conduction_time_i = 12'h008;
    pump_below_level_i = 1'b1;
    cyc(4);
    chk(pump_low_flag_o & global_error_flag_o & supply_error_flag_o, 1'b1);
    chk({static_discharge_o, driver_off_o}, 12'h002);
    cyc(12);
    chk(driver_off_o, 1'b1);
    clr;
    chk(pump_low_flag_o, 1'b1);
    pump_below_level_i = 1'b0;
    cyc(3);
    clr;
    chk(pump_low_flag_o | global_error_flag_o | driver_off_o, 1'b0);
  endtask
  // delay reports on mask or cross time out
  task automatic t_meas;
    {ds_mask_time_i, cross_conduction_time_i} = {12'h005, 12'h007};
    pwm_cmd_i = 1'b1;
    cyc(12);
    chk(ton_delay_o, 12'h005);
    pwm_cmd_i = 1'b0;
    cyc(12);
    chk({toff_delay_o, generator_mode_o}, 12'h00e);
    {generator_detect_enable_i, pwm_cmd_i, ds_mask_time_i} = {2'h3, 12'h009};
    cyc(16);
    chk(ton_delay_o, 12'h005);
    active_cmd_i = 1'b1;
    cyc(16);
    chk(ton_delay_o, 12'h009);
    active_cmd_i = 1'b0;
    cyc(16);
    chk(generator_mode_o, 1'b1);
  endtask
  // re-enable, progress quarters, timeout, frozen field
  task automatic t_timeout;
    host.send(2'h3, 5'h00);
    chk(wd_off_bit_o, 1'b0);
    w1(1'b0, 1'b0, 1'b0);
    for (int q = 0; q < 4; q++) begin
      cyc(q == 0 ? 4 : 8);
      chk(wd_progress_field_o, 12'(q));
    end
    chk(failsafe_flag_o, 1'b0);
    wait_fs(12);
    cyc(3);
    chk(wd_progress_field_o, 2'h3);
    chk(bridge_enable_o | wd_toggle_bit_o, 1'b0);
    exit_fs;
  endtask
  // same toggle value, broken exit sequence
  task automatic t_same;
    w1(1'b0, 1'b0, 1'b0);
    host.send(2'h2, 5'h10);
    cyc(1);
    chk(failsafe_flag_o, 1'b1);
    chk(wd_toggle_bit_o, 1'b0);
    host.send(2'h1, 5'h00);
    host.send(2'h2, 5'h10);
    host.send(2'h0, 5'h00);
    host.send(2'h2, 5'h00);
    cyc(1);
    chk(failsafe_flag_o, 1'b1);
    exit_fs;
  endtask
  // long period
  task automatic t_long;
    w1(1'b1, 1'b0, 1'b0);
    chk(wd_period_select_o, 1'b1);
    cyc(100);
    chk(wd_progress_field_o, 2'h3);
    cyc(20);
    chk(failsafe_flag_o, 1'b0);
    wait_fs(20);
  endtask
  // main sequence
  initial begin
    {battery_below_low_off_i, battery_above_high1_i, battery_above_high2_i} = 3'h0;
    {thermal_shutdown_i, generator_detect_enable_i, active_cmd_i, pwm_cmd_i} = 4'h0;
    {out_low_cross_i, out_high_cross_i, tog} = 3'h0;
    {battery_above_low_on_i, battery_below_high_on_i, pump_below_level_i} = 3'h7;
    {ds_mask_time_i, cross_conduction_time_i} = {12'h028, 12'h028};
    reset_n_i = 1'b0;
    cyc(2);
    chk({driver_off_o, bridge_enable_o, failsafe_flag_o}, 12'h004);
    reset_n_i = 1'b1;
    t_start;
    t_uv;
    t_ov;
    t_pump;
    t_meas;
    t_timeout;
    t_same;
    t_long;
    tally_and_finish;
  end
  // hang guard
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
endmodule
